// ==== fan_cfg_defines.vh ====
/*
  Constants for the fan controller start-up and timebase block:
  clock rates, timing counts, register offsets, fields, reset values.
  Assumes a 20 MHz system clock and a 16-bit plain register port.
*/
`ifndef FAN_CFG_DEFINES_VH
`define FAN_CFG_DEFINES_VH

// -----------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------
`define FC_CLK_HZ          20000000
`define FC_OSC_HZ          32768
`define FC_HALF_STEP       (2 * `FC_OSC_HZ)
`define FC_SDA_TIMEOUT_MS  25
`define FC_SDA_TIMEOUT_CYC (`FC_SDA_TIMEOUT_MS * (`FC_CLK_HZ / 1000))
`define FC_CNT_DIV         4
`define FC_TACH_BITS       11
`define FC_STRAP_WAIT      2'h2

// -----------------------------------------------------------
// Watchdog modes and periods in seconds
// -----------------------------------------------------------
`define FC_WD_OFF          2'h0
`define FC_WD_STRAP_ON     2'h1
`define FC_WD_SEC_1        5'h05
`define FC_WD_SEC_2        5'h0a
`define FC_WD_SEC_3        5'h1e

// -----------------------------------------------------------
// Address pin connection codes
// -----------------------------------------------------------
`define FC_ADDR_GND        2'h0
`define FC_ADDR_VCC        2'h1
`define FC_ADDR_SDA        2'h2
`define FC_ADDR_SCL        2'h3

// -----------------------------------------------------------
// Registers and fields
// -----------------------------------------------------------
`define FC_REG_CTRL        4'h0
`define FC_REG_TACH_CFG    4'h1
`define FC_REG_TACH_RES    4'h2
`define FC_REG_STATUS      4'h3
`define FC_CTRL_XTAL_EN    0
`define FC_CTRL_WD_LO      1
`define FC_CTRL_WD_HI      2
`define FC_CTRL_WD_KICK    3
`define FC_TCFG_PER_LO     0
`define FC_TCFG_PER_HI     1
`define FC_CTRL_RST        3'h0
`define FC_TCFG_RST        2'h0

`endif

// ==== fan_cfg_timebase.v ====
/*
  Start-up strap capture, timebase oscillator selection, tach count
  clock and period counter, bus watchdog, address pin decode and
  SDA stuck-low release for a six-channel fan controller.
  Assumes all pins are asynchronous to clock; the serial engine and
  register master run on clock; straps are stable at reset release.
*/
`timescale 1ns/10ps
`include "fan_cfg_defines.vh"

module fan_cfg_timebase
#(
  parameter SDA_TIMEOUT_CYC = `FC_SDA_TIMEOUT_CYC,
  parameter TICKS_PER_SEC   = `FC_OSC_HZ,
  parameter TACH_BITS       = `FC_TACH_BITS
)
(
  input  wire                 clock,
  input  wire                 rst,
  input  wire [3:0]           reg_addr,
  input  wire [15:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [15:0]          reg_rdata,
  input  wire                 pwm_freq_strap,
  input  wire                 spin_up_strap,
  input  wire                 watchdog_strap,
  input  wire                 addr_select_0,
  input  wire                 addr_select_1,
  input  wire                 crystal_in,
  output reg                  crystal_out,
  output reg                  osc_clock_output,
  input  wire                 tach_in,
  input  wire                 scl_in,
  input  wire                 sda_in,
  output wire                 sda_out,
  output wire                 sda_oe,
  input  wire                 sda_drive_low,
  output reg                  i2c_if_reset,
  output reg  [3:0]           i2c_addr,
  output reg                  i2c_addr_valid,
  output reg                  pwm_freq_init,
  output reg                  spin_up_init,
  output reg                  straps_valid,
  output reg                  tach_count_tick,
  output reg                  watchdog_expired
);

  // -----------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------
  localparam NPIN = 9;
  localparam P_WD = 0, P_SPIN = 1, P_FREQ = 2, P_A0 = 3, P_A1 = 4;
  localparam P_SDA = 5, P_SCL = 6, P_TACH = 7, P_XTAL = 8;

  wire [NPIN-1:0] pin_raw;       // Raw pins in fixed order
  reg  [NPIN-1:0] pin_meta_q;    // First stage, read only by second
  reg  [NPIN-1:0] pin_sync_q;    // Synchronised pins
  reg  [NPIN-1:0] pin_prev_q;    // One cycle older, for edges

  assign pin_raw = {crystal_in, tach_in, scl_in, sda_in, addr_select_1,
                    addr_select_0, pwm_freq_strap, spin_up_strap,
                    watchdog_strap};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_sync
      // Two flip-flops, then an edge history stage
      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
          pin_prev_q[gi] <= 1'b0;
        end
        else
        begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
          pin_prev_q[gi] <= pin_sync_q[gi];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------
  // Registers written by software and strap capture
  // -----------------------------------------------------------
  reg        xtal_en_q;          // Crystal enable
  reg  [1:0] wd_mode_q;          // Watchdog mode
  reg  [1:0] tach_per_q;         // Tach periods select
  reg  [1:0] strap_cnt_q;        // Wait for synchronisers
  wire       wr_ctrl = reg_wr & (reg_addr == `FC_REG_CTRL);
  wire       wd_kick = wr_ctrl & reg_wdata[`FC_CTRL_WD_KICK];
  wire       strap_take = ~straps_valid & (strap_cnt_q == `FC_STRAP_WAIT);

  // Control writes and one-time strap capture
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {wd_mode_q, xtal_en_q} <= `FC_CTRL_RST;
      tach_per_q    <= `FC_TCFG_RST;
      strap_cnt_q   <= 2'h0;
      straps_valid  <= 1'b0;
      pwm_freq_init <= 1'b0;
      spin_up_init  <= 1'b0;
    end
    else
    begin
      if (!straps_valid)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_take)
      begin
        straps_valid  <= 1'b1;
        pwm_freq_init <= pin_sync_q[P_FREQ];
        spin_up_init  <= pin_sync_q[P_SPIN];
        wd_mode_q     <= pin_sync_q[P_WD] ? `FC_WD_STRAP_ON : `FC_WD_OFF;
      end
      else if (wr_ctrl)
      begin
        xtal_en_q <= reg_wdata[`FC_CTRL_XTAL_EN];
        wd_mode_q <= reg_wdata[`FC_CTRL_WD_HI:`FC_CTRL_WD_LO];
      end
      if (reg_wr && reg_addr == `FC_REG_TACH_CFG)
        tach_per_q <= reg_wdata[`FC_TCFG_PER_HI:`FC_TCFG_PER_LO];
    end
  end

  // -----------------------------------------------------------
  // Timebase oscillator
  // -----------------------------------------------------------
  reg  [24:0] osc_acc_q;         // Phase accumulator
  reg         int_clk_q;         // Internal 32768 Hz square wave
  reg         int_rise_q;        // Internal rising edge pulse
  wire [31:0] osc_sum_w = {7'h00, osc_acc_q} + `FC_HALF_STEP;  // Full-width step sum
  wire [31:0] osc_sub_w = osc_sum_w - `FC_CLK_HZ;               // Sum after one wrap
  wire [25:0] osc_sum = osc_sum_w[25:0];                       // Sum kept for compare
  wire        osc_wrap = (osc_sum >= `FC_CLK_HZ);
  wire        xtal_rise = pin_sync_q[P_XTAL] & ~pin_prev_q[P_XTAL];
  wire        tosc_tick = xtal_en_q ? xtal_rise : int_rise_q;

  // Internal oscillator from the system clock
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      osc_acc_q  <= 25'h0;
      int_clk_q  <= 1'b0;
      int_rise_q <= 1'b0;
    end
    else
    begin
      if (osc_wrap)
        osc_acc_q <= osc_sub_w[24:0];
      else
        osc_acc_q <= osc_sum[24:0];
      if (osc_wrap)
        int_clk_q <= ~int_clk_q;
      int_rise_q <= osc_wrap & ~int_clk_q;
    end
  end

  // Clock output and crystal drive
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      osc_clock_output <= 1'b0;
      crystal_out      <= 1'b0;
    end
    else
    begin
      osc_clock_output <= xtal_en_q ? pin_sync_q[P_XTAL] : int_clk_q;
      // Crystal stays quiet until enabled
      crystal_out      <= xtal_en_q & ~pin_sync_q[P_XTAL];
    end
  end

  // -----------------------------------------------------------
  // Tach count clock and period counter
  // -----------------------------------------------------------
  reg  [1:0]           div_q;    // Divide timebase by four
  reg  [TACH_BITS-1:0] tach_cnt_q;
  reg  [TACH_BITS-1:0] tach_res_q;
  reg  [3:0]           tach_per_cnt_q;
  reg                  tach_res_new_q;
  wire                 tach_rise = pin_sync_q[P_TACH] & ~pin_prev_q[P_TACH];
  wire [3:0]           tach_target = 4'h1 << tach_per_q;
  wire                 tach_full = &tach_cnt_q;

  // Counting clock and measurement
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_q           <= 2'h0;
      tach_count_tick <= 1'b0;
      tach_cnt_q      <= {TACH_BITS{1'b0}};
      tach_res_q      <= {TACH_BITS{1'b0}};
      tach_per_cnt_q  <= 4'h0;
      tach_res_new_q  <= 1'b0;
    end
    else
    begin
      // count clock is timebase over four
      if (tosc_tick)
        div_q <= div_q + 2'h1;
      tach_count_tick <= tosc_tick & (div_q == `FC_CNT_DIV - 1);
      if (tach_rise && tach_per_cnt_q + 4'h1 >= tach_target)
      begin
        tach_res_q     <= tach_cnt_q;
        tach_res_new_q <= 1'b1;
        tach_cnt_q     <= {TACH_BITS{1'b0}};
        tach_per_cnt_q <= 4'h0;
      end
      else
      begin
        if (tach_rise)
          tach_per_cnt_q <= tach_per_cnt_q + 4'h1;
        if (tach_count_tick && !tach_full)
          tach_cnt_q <= tach_cnt_q + 1'b1;
        if (reg_rd && reg_addr == `FC_REG_TACH_RES)
          tach_res_new_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------
  // Bus watchdog on the timebase
  // -----------------------------------------------------------
  reg  [19:0] wd_sub_q;          // Ticks within one second
  reg  [4:0]  wd_sec_q;          // Whole seconds elapsed
  reg  [4:0]  wd_limit;          // Seconds for current mode

  // Period from mode
  always @*
  begin
    case (wd_mode_q)
      2'h1:    wd_limit = `FC_WD_SEC_1;
      2'h2:    wd_limit = `FC_WD_SEC_2;
      2'h3:    wd_limit = `FC_WD_SEC_3;
      default: wd_limit = 5'h00;
    endcase
  end

  // Seconds counter, kicked by software
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wd_sub_q         <= 20'h0;
      wd_sec_q         <= 5'h00;
      watchdog_expired <= 1'b0;
    end
    else if (wd_kick || wd_mode_q == `FC_WD_OFF)
    begin
      wd_sub_q         <= 20'h0;
      wd_sec_q         <= 5'h00;
      watchdog_expired <= 1'b0;
    end
    else if (tosc_tick && !watchdog_expired)
    begin
      if (wd_sub_q == TICKS_PER_SEC - 1)
      begin
        wd_sub_q <= 20'h0;
        wd_sec_q <= wd_sec_q + 5'h01;
        if (wd_sec_q + 5'h01 == wd_limit)
          watchdog_expired <= 1'b1;
      end
      else
        wd_sub_q <= wd_sub_q + 20'h1;
    end
  end

  // -----------------------------------------------------------
  // Address pin decode at transaction start
  // -----------------------------------------------------------
  wire       start_det = pin_sync_q[P_SCL] & pin_prev_q[P_SDA] & ~pin_sync_q[P_SDA];
  wire       scl_fall  = pin_prev_q[P_SCL] & ~pin_sync_q[P_SCL];
  reg        addr_wait_q;        // Start seen, wait for SCL low
  reg  [1:0] a_pre_q;            // Pin value while SDA high
  reg  [1:0] a_now_q;            // Pin value just after start
  wire [1:0] a_sync = {pin_sync_q[P_A1], pin_sync_q[P_A0]};
  wire [1:0] a_prev = {pin_prev_q[P_A1], pin_prev_q[P_A0]};
  wire [3:0] a_code;             // Two bits per pin

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_adec
      assign a_code[2*gi+1:2*gi] =
        a_now_q[gi] ? (a_sync[gi] ? `FC_ADDR_VCC : `FC_ADDR_SCL)
                    : (a_pre_q[gi] ? `FC_ADDR_SDA : `FC_ADDR_GND);
    end
  endgenerate

  // Sample at start, decide at first SCL fall
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      addr_wait_q    <= 1'b0;
      a_pre_q        <= 2'h0;
      a_now_q        <= 2'h0;
      i2c_addr       <= 4'h0;
      i2c_addr_valid <= 1'b0;
    end
    else
    begin
      i2c_addr_valid <= 1'b0;
      if (start_det)
      begin
        addr_wait_q <= 1'b1;
        a_pre_q     <= a_prev;
        a_now_q     <= a_sync;
      end
      else if (addr_wait_q && scl_fall)
      begin
        addr_wait_q    <= 1'b0;
        i2c_addr       <= a_code;
        i2c_addr_valid <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------
  // SDA stuck-low release
  // -----------------------------------------------------------
  reg [19:0] sda_low_q;          // Cycles SDA has been low
  reg        sda_rel_q;          // Drive suppressed

  // Timeout counter and release flag
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sda_low_q    <= 20'h0;
      sda_rel_q    <= 1'b0;
      i2c_if_reset <= 1'b0;
    end
    else
    begin
      i2c_if_reset <= 1'b0;
      if (pin_sync_q[P_SDA])
      begin
        sda_low_q <= 20'h0;
        sda_rel_q <= 1'b0;
      end
      else if (sda_low_q == SDA_TIMEOUT_CYC - 1)
      begin
        sda_rel_q    <= 1'b1;
        i2c_if_reset <= ~sda_rel_q;
      end
      else
        sda_low_q <= sda_low_q + 20'h1;
    end
  end

  assign sda_oe  = sda_drive_low & ~sda_rel_q;
  assign sda_out = 1'b0;

  // -----------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------
  // Read data one cycle after strobe
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FC_REG_CTRL:     reg_rdata <= {13'h0000, wd_mode_q, xtal_en_q};
        `FC_REG_TACH_CFG: reg_rdata <= {14'h0000, tach_per_q};
        `FC_REG_TACH_RES: reg_rdata <= {tach_res_new_q, 4'h0, tach_res_q};
        `FC_REG_STATUS:   reg_rdata <= {4'h0, i2c_addr, 1'b0, sda_rel_q,
                                        watchdog_expired, xtal_en_q,
                                        straps_valid, 1'b0,
                                        spin_up_init, pwm_freq_init};
        default:          reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule // fan_cfg_timebase

// ==== fan_cfg_timebase_asserts.sv ====
/* Port checker for the strap, timebase and SDA release block.
   Assumes binding to every fan_cfg_timebase; sees its ports only. */
`timescale 1ns/10ps
module fan_cfg_timebase_asserts
#(
  parameter SDA_TIMEOUT_CYC = 200
)
(
  input wire        clock,
  input wire        rst,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        sda_in,
  input wire        sda_oe,
  input wire        sda_drive_low,
  input wire        i2c_if_reset,
  input wire [3:0]  i2c_addr,
  input wire        i2c_addr_valid,
  input wire        pwm_freq_init,
  input wire        spin_up_init,
  input wire        straps_valid,
  input wire        tach_count_tick,
  input wire        crystal_out,
  input wire        osc_clock_output
);
  // ---------------------------------
  // Helper state
  // ---------------------------------
  reg        xen_q;  // Crystal enable as written
  reg [31:0] low_q;  // Cycles of SDA pin low
  // Shadow enable bit, count SDA low run
  always @(posedge clock or posedge rst)
    if (rst)
    begin
      xen_q <= 1'b0;
      low_q <= 32'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 4'h0)
        xen_q <= reg_wdata[0];
      low_q <= sda_in ? 32'h0 : low_q + 32'h1;
    end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ---------------------------------
  // Properties
  // ---------------------------------
  property p_strap_hold;
    straps_valid |=> straps_valid && $stable({pwm_freq_init, spin_up_init});
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
  property p_rel_cause;
    i2c_if_reset |-> low_q >= SDA_TIMEOUT_CYC;
  endproperty
  a_rel_cause: assert property (p_rel_cause) else $error("early release");
  property p_rel_oe;
    i2c_if_reset |-> !sda_oe ##1 !i2c_if_reset;
  endproperty
  a_rel_oe: assert property (p_rel_oe) else $error("release bad");
  property p_oe_cause;
    sda_oe |-> sda_drive_low;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
  property p_addr_pulse;
    i2c_addr_valid |=> !i2c_addr_valid;
  endproperty
  a_addr_pulse: assert property (p_addr_pulse) else $error("valid long");
  property p_addr_change;
    $changed(i2c_addr) |-> i2c_addr_valid;
  endproperty
  a_addr_change: assert property (p_addr_change) else $error("addr moved");
  property p_tick_space;
    tach_count_tick |=> !tach_count_tick [*8];
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("tick fast");
  property p_xtal_off;
    (!xen_q) [*3] |-> !crystal_out;
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal on");
  property p_osc_slow;
    (!xen_q) [*3] ##0 $changed(osc_clock_output) |=> $stable(osc_clock_output) [*8];
  endproperty
  a_osc_slow: assert property (p_osc_slow) else $error("osc fast");
endmodule // fan_cfg_timebase_asserts

bind fan_cfg_timebase fan_cfg_timebase_asserts #(.SDA_TIMEOUT_CYC(SDA_TIMEOUT_CYC))
  fan_cfg_timebase_asserts_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sda_in(sda_in), .sda_oe(sda_oe),
  .sda_drive_low(sda_drive_low), .i2c_if_reset(i2c_if_reset), .i2c_addr(i2c_addr),
  .i2c_addr_valid(i2c_addr_valid), .pwm_freq_init(pwm_freq_init),
  .spin_up_init(spin_up_init), .straps_valid(straps_valid),
  .tach_count_tick(tach_count_tick), .crystal_out(crystal_out),
  .osc_clock_output(osc_clock_output));

// ==== i2c_host_model.sv ====
/* Serial bus host model: makes START frames and holds SDA low.
   Assumes an SDA pull-up and an open-drain device pull-down. */
`timescale 1ns/10ps
module i2c_host_model
(
  input  wire clock,
  input  wire sda_oe,
  output reg  scl,
  output reg  sda_rel,
  output wire sda_line
);
  // Wired-and with pull-up
  assign sda_line = sda_rel & ~sda_oe;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // START, one SCL low phase, STOP
  task start_frame;
    begin
      repeat (6) @(posedge clock);
      sda_rel <= 1'b0;
      repeat (6) @(posedge clock);
      scl <= 1'b0;
      repeat (6) @(posedge clock);
      scl <= 1'b1;
      repeat (6) @(posedge clock);
      sda_rel <= 1'b1;
    end
  endtask
  // Hold SDA low with SCL high
  task hold_low(input integer n);
    begin
      // Let the previous release settle for one edge
      @(posedge clock);
      sda_rel <= 1'b0;
      repeat (n) @(posedge clock);
      sda_rel <= 1'b1;
    end
  endtask
endmodule // i2c_host_model

// ==== fan_cfg_timebase_bench.sv ====
/* Self-checking bench for fan_cfg_timebase.
   Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
module fan_cfg_timebase_bench;
  localparam TO = 200;  // Shortened SDA timeout
  reg          clock, rst, reg_wr, reg_rd, rd_d, crystal_in, tach_in, sda_drive_low;
  reg  [3:0]   reg_addr;
  reg  [15:0]  reg_wdata;
  reg  [2:0]   st;      // Straps {pwm, spin, wd}
  reg  [1:0]   c0, c1;  // Address pin hookups
  wire [15:0]  reg_rdata;
  wire [3:0]   i2c_addr;
  wire         a0, a1, scl, sda, sda_oe, i2c_if_reset, i2c_addr_valid, tick, wd_exp, osc;
  integer      errors, comparisons, seed, r, n, i, nres, w;
  time         t0;      // Start of a clock output period
  logic [15:0] exp_q[$];  // Expected results, oldest first
  assign a0 = c0 == 2'h0 ? 1'b0 : c0 == 2'h1 ? 1'b1 : c0 == 2'h2 ? sda : scl;
  assign a1 = c1 == 2'h0 ? 1'b0 : c1 == 2'h1 ? 1'b1 : c1 == 2'h2 ? sda : scl;
  fan_cfg_timebase #(.SDA_TIMEOUT_CYC(TO), .TICKS_PER_SEC(4)) fan_cfg_timebase_inst (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_freq_strap(st[2]),
    .spin_up_strap(st[1]), .watchdog_strap(st[0]), .addr_select_0(a0),
    .addr_select_1(a1), .crystal_in(crystal_in), .crystal_out(), .osc_clock_output(osc),
    .tach_in(tach_in), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .sda_drive_low(sda_drive_low), .i2c_if_reset(i2c_if_reset), .i2c_addr(i2c_addr),
    .i2c_addr_valid(i2c_addr_valid), .pwm_freq_init(), .spin_up_init(),
    .straps_valid(), .tach_count_tick(tick), .watchdog_expired(wd_exp));
  i2c_host_model i2c_host_model_inst (.clock(clock), .sda_oe(sda_oe), .scl(scl),
    .sda_rel(), .sda_line(sda));
  // Compare and count
  task check(input [15:0] seen, input [15:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want)
      begin
        errors = errors + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  // One register cycle; a read notes its answer
  task bus(input w, input [3:0] a, input [15:0] d);
    begin
      if (!w)
        exp_q.push_back(d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
    end
  endtask
  // Drop strobes and wait
  task idle(input integer k);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (k) @(posedge clock);
    end
  endtask
  // Tach rise midway between count ticks
  task tach_edge;
    begin
      @(posedge tick);
      repeat (16) @(posedge clock);
      tach_in <= 1'b1;
      repeat (4) @(posedge clock);
      tach_in <= 1'b0;
    end
  endtask
  // Wait for a level, counting cycles; sel 1 watches the watchdog
  task wait_hi(input integer lim, input integer sel);
    begin
      n = 0;
      while ((sel ? wd_exp : i2c_if_reset) !== 1'b1 && n < lim)
      begin
        @(posedge clock);
        n = n + 1;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Free-running crystal, phase apart from clock
  initial
  begin
    crystal_in = 1'b0;
    #7;
    forever #200 crystal_in = ~crystal_in;
  end
  // Answer watcher: read data or address decode
  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    if (i2c_if_reset === 1'b1)
      nres = nres + 1;
    if (rd_d || i2c_addr_valid === 1'b1)
      check(rd_d ? reg_rdata : {12'h000, i2c_addr}, exp_q.pop_front());
  end
  initial
  begin
    #1000000;
    errors = errors + 1;
    print_verdict;
  end
  initial
  begin
    seed = 82;
    errors = 0;
    comparisons = 0;
    nres = 0;
    rd_d = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, tach_in, sda_drive_low} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    {c1, c0} = 4'h0;
    r = $random(seed);
    st = r[2:0];
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    bus(0, 4'h3, {12'h000, 4'h8} | {14'h0, st[1], st[2]}); // status after capture
    bus(0, 4'h0, {13'h0, 1'b0, st[0], 1'b0}); // strap watchdog mode
    bus(0, 4'h9, 16'h0000); // unmapped reads zero
    st <= ~st;
    idle(4);
    bus(0, 4'h3, {12'h000, 4'h8} | {14'h0, ~st[1], ~st[2]}); // later pins ignored
    idle(3);
    @(posedge osc);
    t0 = $time;
    @(posedge osc);
    check({15'h0, $time - t0 >= 30450 && $time - t0 <= 30600}, 16'h0001);
    for (i = 0; i < 16; i = i + 1)
    begin
      {c1, c0} <= i[3:0];
      exp_q.push_back({12'h000, i[3:0]});
      i2c_host_model_inst.start_frame; // each pin state per frame
    end
    i2c_host_model_inst.hold_low(TO - 50);
    check(nres, 0); // short low is kept
    idle(4);
    sda_drive_low <= 1'b1;
    wait_hi(TO + 60, 0);
    check({15'h0, n >= TO && n <= TO + 10}, 16'h0001); // release after timeout
    sda_drive_low <= 1'b0;
    bus(1, 4'h0, 16'h0001); // crystal enable
    bus(1, 4'h1, 16'h0003);
    bus(0, 4'h1, 16'h0003);
    bus(0, 4'h0, 16'h0001);
    idle(1);
    r = $random(seed);
    n = 5 + r[3:0];
    tach_edge;
    repeat (n - 1) @(posedge tick);
    tach_edge;
    bus(1, 4'h1, 16'h0001);
    idle(1);
    tach_edge;
    repeat (n - 1) @(posedge tick);
    tach_edge;
    repeat (n - 1) @(posedge tick);
    tach_edge;
    bus(0, 4'h2, 16'h8000 | {n[14:0], 1'b0}); // ticks over two periods
    bus(0, 4'h2, {n[14:0], 1'b0}); // flag cleared by read
    // Each watchdog mode, timed on crystal ticks
    for (i = 1; i < 4; i = i + 1)
    begin
      w = (i == 1 ? 5 : i == 2 ? 10 : 30) * 32;
      bus(1, 4'h0, {12'h000, 1'b1, i[1:0], 1'b1});
      idle(1);
      wait_hi(w + 60, 1);
      check({15'h0, n >= w - 20 && n <= w + 25}, 16'h0001); // watchdog on crystal ticks
    end
    bus(1, 4'h0, 16'h0001);
    idle(3);
    check({15'h0, wd_exp}, 16'h0000); // mode off clears
    check(exp_q.size(), 0);
    print_verdict;
  end
endmodule // fan_cfg_timebase_bench
